// ==== cmf_defines.vh ====
/*
 Register offsets, field positions, reset values and codes of the CAN
 mode and FIFO control block.
 Assumes a classic Wishbone slave with 32-bit aligned word registers.
*/
`ifndef CMF_DEFINES_VH
`define CMF_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CMF_OFF_CTRL1 6'h00
`define CMF_OFF_CTRL2 6'h04
`define CMF_OFF_IRQ_CAUSE_CODE 6'h08
`define CMF_OFF_FCTRL 6'h0C
`define CMF_OFF_FSTAT 6'h10
`define CMF_OFF_INTF 6'h14
`define CMF_OFF_EVENT 6'h18

// ----------------------------------------
// Control one field positions
// ----------------------------------------
`define CMF_BIT_HALT 13
`define CMF_BIT_ABORT 12
`define CMF_BIT_CKS 11
`define CMF_REQ_HI 10
`define CMF_REQ_LO 8
`define CMF_CUR_HI 7
`define CMF_CUR_LO 5
`define CMF_BIT_CAP 3
`define CMF_BIT_WIN 0

// ----------------------------------------
// Modes
// ----------------------------------------
`define CMF_MODE_NORMAL 3'h0
`define CMF_MODE_DISABLE 3'h1
`define CMF_MODE_LOOP 3'h2
`define CMF_MODE_LISTEN 3'h3
`define CMF_MODE_CONFIG 3'h4
`define CMF_MODE_RSV5 3'h5
`define CMF_MODE_RSV6 3'h6
`define CMF_MODE_ALL 3'h7

// ----------------------------------------
// Cause codes and limits
// ----------------------------------------
`define CMF_IC_NONE 7'h40
`define CMF_IC_ERR 7'h41
`define CMF_IC_WAKE 7'h42
`define CMF_IC_OVF 7'h43
`define CMF_IC_FIFO 7'h44
`define CMF_DATA_MATCH_BIT_COUNT_MAX 5'h11
`define CMF_FILT_MAX 5'h0F
`define CMF_DMA_BUFFER_COUNT_RSV 3'h7
`define CMF_IDLE_BITS 4'hB
`define CMF_BIT_RATE_HZ 500000
`define CMF_CLK_HZ 25000000
`define CMF_BIT_CYCLES (`CMF_CLK_HZ / `CMF_BIT_RATE_HZ)

`endif

// ==== cmf_mode_fifo.v ====
/*
 CAN mode request/acknowledge, abort, options, cause code and FIFO
 pointers, with a classic Wishbone register slave.
 Assumes the protocol engine feeds events and status
 synchronously on clk_i; can_rx_i is asynchronous and is synchronised.
*/
// Our own choices: the register addresses and the Wishbone register port.
// How it works
// - Software writes a 3-bit mode request; six codes defined, two reserved.
// - Read-only current-mode field shows the mode actually entered, same coding.
// - Mode changes only after bus idle, eleven recessive bits in a row.
// - Request and current mode both reset to configuration, code 100.
// - Halt-in-idle bit stops the module while the device sits in Idle.
// - Abort-all bit aborts every pending transmit; hardware clears it after.
// - Clock-select bit picks module clock twice or equal to peripheral clock.
// - Receive-capture enable gives a capture pulse per received message.
// - Window-select bit chooses filter window when one, buffer window when zero.
// - Five-bit data match count; codes above 10001 are invalid.
// - Read-only matched filter index, 0 to 15; higher codes reserved.
// - Cause code 1000000 means none; error, wake, overflow, FIFO follow.
// - Buffer interrupts report the low three bits of the buffer number as cause code: transmit 0 to 7, receive 8 to 15.
// - Three-bit DMA buffer count, codes 0 to 6 valid, 7 reserved.
// - Five-bit field names the buffer where the receive FIFO begins.
// - Read-only six-bit next-read pointer names next FIFO buffer to read.
// - Interrupt flags clear by writing zero; writing one does nothing.
// - Error flag raised by bus-off, passive or warning status sources.
`timescale 1ns/1ns
`include "cmf_defines.vh"

module cmf_mode_fifo #(
	parameter BIT_CYCLES = `CMF_BIT_CYCLES,
	parameter FIFO_TOP = 31
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire can_rx_i,
	input wire device_idle_i,
	input wire msg_rx_i,
	input wire [4:0] filter_hit_i,
	input wire [3:0] rx_buf_i,
	input wire rx_buf_irq_i,
	input wire [3:0] tx_buf_i,
	input wire tx_buf_irq_i,
	input wire wake_i,
	input wire rx_ovf_i,
	input wire fifo_almost_i,
	input wire [5:0] err_state_i,
	input wire tx_pending_i,
	input wire fifo_read_i,
	output reg [2:0] current_op_field_o,
	output reg module_run_o,
	output reg abort_all_tx_o,
	output reg module_clk_select_o,
	output reg rx_capture_o,
	output reg map_window_select_o,
	output reg [4:0] data_match_bit_count_o,
	output reg [2:0] dma_buffer_count_o
);

// ----------------------------------------
// Registers and synchroniser
// ----------------------------------------
reg rx_meta;
reg rx_sync;
reg halt_in_idle;
reg abort_all_tx;
reg [2:0] requested_op_field;
reg [2:0] current_op_field;
reg [4:0] data_match_bit_count;
reg [4:0] matched_filter_index;
reg [6:0] irq_cause_code;
reg [2:0] dma_buffer_count;
reg [4:0] fifo_start_buffer;
wire [5:0] fifo_write_ptr;
wire [5:0] fifo_read_ptr;
reg [15:0] bit_cnt;
reg [3:0] idle_bits;
reg [4:0] irq_flags;
reg [5:0] err_prev;
reg [31:0] next_rdata;
reg [4:0] next_flags;
reg cap_en;

wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
wire rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
wire lo_en = wb_sel_i[0];
wire hi_en = wb_sel_i[1];
wire wr_ctrl1 = wr & (wb_adr_i == `CMF_OFF_CTRL1);
wire wr_ctrl2 = wr & (wb_adr_i == `CMF_OFF_CTRL2);
wire wr_fctrl = wr & (wb_adr_i == `CMF_OFF_FCTRL);
wire wr_intf = wr & (wb_adr_i == `CMF_OFF_INTF) & lo_en;
wire bus_idle = (idle_bits == `CMF_IDLE_BITS);
wire req_ok = (requested_op_field != `CMF_MODE_RSV5) &&
	(requested_op_field != `CMF_MODE_RSV6);
wire running = ~(halt_in_idle & device_idle_i);
wire err_rise = |(err_state_i & ~err_prev);
wire [4:0] ptr_top = (fifo_start_buffer > FIFO_TOP[4:0]) ?
	fifo_start_buffer : FIFO_TOP[4:0];

// ----------------------------------------
// Bus line sync and idle detector
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		// Starts recessive so reset does not look like a dominant bit
		rx_meta <= 1'b1;
		rx_sync <= 1'b1;
		bit_cnt <= 16'h0000;
		idle_bits <= 4'h0;
	end else begin
		rx_meta <= can_rx_i;
		rx_sync <= rx_meta;
		if (!rx_sync) begin
			bit_cnt <= 16'h0000;
			idle_bits <= 4'h0;
		end else if (bit_cnt == BIT_CYCLES[15:0] - 16'h0001) begin
			bit_cnt <= 16'h0000;
			// Saturates at eleven; stays idle until a dominant bit
			if (!bus_idle)
				idle_bits <= idle_bits + 4'h1;
		end else begin
			bit_cnt <= bit_cnt + 16'h0001;
		end
	end
end

// ----------------------------------------
// Control registers and mode switch
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		halt_in_idle <= 1'b0;
		abort_all_tx <= 1'b0;
		module_clk_select_o <= 1'b0;
		requested_op_field <= `CMF_MODE_CONFIG;
		current_op_field <= `CMF_MODE_CONFIG;
		map_window_select_o <= 1'b0;
		data_match_bit_count <= 5'h00;
		dma_buffer_count <= 3'h0;
		fifo_start_buffer <= 5'h00;
	end else begin
		if (wr_ctrl1 & hi_en) begin
			halt_in_idle <= wb_dat_i[`CMF_BIT_HALT];
			module_clk_select_o <= wb_dat_i[`CMF_BIT_CKS];
			requested_op_field <= wb_dat_i[`CMF_REQ_HI:`CMF_REQ_LO];
		end
		if (wr_ctrl1 & lo_en)
			map_window_select_o <= wb_dat_i[`CMF_BIT_WIN];
		// A software set wins; hardware clears it only once nothing is pending
		if (wr_ctrl1 & hi_en & wb_dat_i[`CMF_BIT_ABORT])
			abort_all_tx <= 1'b1;
		else if (abort_all_tx & ~tx_pending_i)
			abort_all_tx <= 1'b0;
		// Reserved requests are stored but never entered
		if (bus_idle & req_ok & running)
			current_op_field <= requested_op_field;
		// Invalid match counts and reserved DMA codes are dropped
		if (wr_ctrl2 & lo_en & (wb_dat_i[4:0] <= `CMF_DATA_MATCH_BIT_COUNT_MAX))
			data_match_bit_count <= wb_dat_i[4:0];
		if (wr_fctrl & hi_en & (wb_dat_i[15:13] != `CMF_DMA_BUFFER_COUNT_RSV))
			dma_buffer_count <= wb_dat_i[15:13];
		if (wr_fctrl & lo_en)
			fifo_start_buffer <= wb_dat_i[4:0];
	end
end

// ----------------------------------------
// Capture, cause code, filter hit, flags
// ----------------------------------------
always @* begin
	next_flags = irq_flags;
	if (wr_intf)
		next_flags = irq_flags & wb_dat_i[4:0];
	// Sets come after the clear, so an event in the same cycle wins
	if (err_rise)
		next_flags[0] = 1'b1;
	if (wake_i)
		next_flags[1] = 1'b1;
	if (rx_ovf_i)
		next_flags[2] = 1'b1;
	if (fifo_almost_i)
		next_flags[3] = 1'b1;
	if (rx_buf_irq_i | tx_buf_irq_i)
		next_flags[4] = 1'b1;
end

always @(posedge clk_i) begin
	if (rst_i) begin
		abort_all_tx_o <= 1'b0;
		module_run_o <= 1'b1;
		irq_flags <= 5'h00;
		err_prev <= 6'h00;
		irq_cause_code <= `CMF_IC_NONE;
		matched_filter_index <= 5'h00;
		rx_capture_o <= 1'b0;
	end else begin
		abort_all_tx_o <= abort_all_tx;
		module_run_o <= running;
		err_prev <= err_state_i;
		irq_flags <= next_flags;
		rx_capture_o <= msg_rx_i & cap_en;
		if (msg_rx_i & (filter_hit_i <= `CMF_FILT_MAX))
			matched_filter_index <= filter_hit_i;
		// Fixed priority; buffer codes keep their group bit
		if (next_flags[0])
			irq_cause_code <= `CMF_IC_ERR;
		else if (next_flags[1])
			irq_cause_code <= `CMF_IC_WAKE;
		else if (next_flags[2])
			irq_cause_code <= `CMF_IC_OVF;
		else if (next_flags[3])
			irq_cause_code <= `CMF_IC_FIFO;
		else if (next_flags[4] & tx_buf_irq_i)
			irq_cause_code <= {4'h0, tx_buf_i[2:0]};
		else if (next_flags[4] & rx_buf_irq_i)
			irq_cause_code <= {3'h0, 1'b1, rx_buf_i[2:0]};
		else if (!next_flags[4])
			irq_cause_code <= `CMF_IC_NONE;
	end
end

always @(posedge clk_i) begin
	if (rst_i)
		cap_en <= 1'b0;
	else if (wr_ctrl1 & lo_en)
		cap_en <= wb_dat_i[`CMF_BIT_CAP];
end

// ----------------------------------------
// FIFO pointers
// ----------------------------------------
cmf_fifo_ptr i_write_ptr (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.load_i(wr_fctrl & lo_en),
	.start_i(wb_dat_i[4:0]),
	.top_i(ptr_top),
	.step_i(msg_rx_i & running),
	.ptr_o(fifo_write_ptr)
);

cmf_fifo_ptr i_read_ptr (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.load_i(wr_fctrl & lo_en),
	.start_i(wb_dat_i[4:0]),
	.top_i(ptr_top),
	.step_i(fifo_read_i),
	.ptr_o(fifo_read_ptr)
);

// ----------------------------------------
// Wishbone read mux and outputs
// ----------------------------------------
always @* begin
	next_rdata = 32'h00000000;
	case (wb_adr_i)
	`CMF_OFF_CTRL1: begin
		next_rdata[`CMF_BIT_HALT] = halt_in_idle;
		next_rdata[`CMF_BIT_ABORT] = abort_all_tx;
		next_rdata[`CMF_BIT_CKS] = module_clk_select_o;
		next_rdata[`CMF_REQ_HI:`CMF_REQ_LO] = requested_op_field;
		next_rdata[`CMF_CUR_HI:`CMF_CUR_LO] = current_op_field;
		next_rdata[`CMF_BIT_CAP] = cap_en;
		next_rdata[`CMF_BIT_WIN] = map_window_select_o;
	end
	`CMF_OFF_CTRL2: next_rdata[4:0] = data_match_bit_count;
	`CMF_OFF_IRQ_CAUSE_CODE: begin
		next_rdata[12:8] = matched_filter_index;
		next_rdata[6:0] = irq_cause_code;
	end
	`CMF_OFF_FCTRL: begin
		next_rdata[15:13] = dma_buffer_count;
		next_rdata[4:0] = fifo_start_buffer;
	end
	`CMF_OFF_FSTAT: begin
		next_rdata[13:8] = fifo_write_ptr;
		next_rdata[5:0] = fifo_read_ptr;
	end
	`CMF_OFF_INTF: begin
		next_rdata[13:8] = err_state_i;
		next_rdata[4:0] = irq_flags;
	end
	// Unmapped offsets read zero
	default: next_rdata = 32'h00000000;
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h00000000;
		current_op_field_o <= `CMF_MODE_CONFIG;
		data_match_bit_count_o <= 5'h00;
		dma_buffer_count_o <= 3'h0;
	end else begin
		// Every access is acked, so a stray address cannot hang the bus
		wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		if (rd)
			wb_dat_o <= next_rdata;
		current_op_field_o <= current_op_field;
		data_match_bit_count_o <= data_match_bit_count;
		dma_buffer_count_o <= dma_buffer_count;
	end
end

endmodule

// ----------------------------------------
// FIFO pointer with wrap
// ----------------------------------------
module cmf_fifo_ptr (
	input wire clk_i,
	input wire rst_i,
	input wire load_i,
	input wire [4:0] start_i,
	input wire [4:0] top_i,
	input wire step_i,
	output reg [5:0] ptr_o
);

// Wrap back to the start buffer past the last RAM buffer
always @(posedge clk_i) begin
	if (rst_i)
		ptr_o <= 6'h00;
	else if (load_i)
		ptr_o <= {1'b0, start_i};
	else if (step_i)
		ptr_o <= (ptr_o[4:0] >= top_i) ? {1'b0, start_i} :
			ptr_o + 6'h01;
end

endmodule

// ==== cmf_chk.sv ====
/* Assertions on the ports of the CAN mode and FIFO control block.
 Bound to that block; sees its ports only. */
`timescale 1ns/1ns
module cmf_chk #(
	parameter BIT_CYCLES = 4
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire can_rx_i,
	input wire device_idle_i,
	input wire msg_rx_i,
	input wire tx_pending_i,
	input wire [2:0] current_op_field_o,
	input wire module_run_o,
	input wire abort_all_tx_o,
	input wire rx_capture_o,
	input wire [4:0] data_match_bit_count_o,
	input wire [2:0] dma_buffer_count_o
);
	// Raw recessive run; the synchroniser only delays it
	int rec = 0;
	always @(posedge clk_i) rec <= can_rx_i ? rec + 1 : 0;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("access not answered");
	a_mode_idle: assert property ($changed(current_op_field_o) |->
		rec >= 11 * BIT_CYCLES) else $error("mode changed on busy bus");
	a_mode_legal: assert property (current_op_field_o != 3'h5 &&
		current_op_field_o != 3'h6) else $error("reserved mode entered");
	a_cap_cause: assert property (rx_capture_o |-> $past(msg_rx_i))
		else $error("capture without message");
	a_halt_cause: assert property (!module_run_o |-> $past(device_idle_i))
		else $error("halted outside idle");
	a_abort_hold: assert property (abort_all_tx_o && tx_pending_i |=>
		abort_all_tx_o) else $error("abort dropped while pending");
	a_abort_clear: assert property (abort_all_tx_o && !tx_pending_i |->
		##[1:3] !abort_all_tx_o) else $error("abort not cleared");
	a_match_legal: assert property (data_match_bit_count_o <= 5'h11)
		else $error("invalid match count");
	a_dma_legal: assert property (dma_buffer_count_o != 3'h7)
		else $error("reserved buffer count");
	c_mode: cover property ($changed(current_op_field_o));
	c_cap: cover property (rx_capture_o);
	c_halt: cover property (!module_run_o);
	c_abort: cover property ($fell(abort_all_tx_o));
endmodule

// ==== cmf_bus_node.sv ====
/* Other CAN nodes on the shared bus, seen as the received level.
 Recessive (pulled high) unless a frame is in progress. */
`timescale 1ns/1ns
module cmf_bus_node #(
	parameter BIT_CYCLES = 4
) (
	input wire clk_i,
	input wire busy_i,
	output reg can_rx_o
);
	integer cnt = 0;
	initial can_rx_o = 1'b1;
	// While busy, one dominant bit in three: the bus never looks idle then
	always @(posedge clk_i) begin
		cnt <= (cnt + 1) % (3 * BIT_CYCLES);
		can_rx_o <= !(busy_i && cnt < BIT_CYCLES);
	end
endmodule

// ==== cmf_mode_fifo_bench.sv ====
/* Self-checking bench of the CAN mode and FIFO control block.
 Needs the block, its checker and the bus node model. */
`timescale 1ns/1ns
module cmf_mode_fifo_bench;
	localparam BIT_CYCLES = 4;
	reg clk_i = 0, rst_i = 1, cyc = 0, we = 0, busy = 0;
	reg idle = 0, msg = 0, pend = 0, fread = 0;
	reg [5:0] adr = 0, ev = 0;
	reg [15:0] wdat = 0;
	wire [31:0] rdat;
	wire ack, rx, run, abt, cks, cap, map_window_select;
	wire [2:0] cur, dma;
	wire [4:0] dnc;
	integer err_count = 0, checks_done = 0, i;
	logic [22:0] rows [18] = '{23'h000480, 23'h040000, 23'h080040,
		23'h0C0000, 23'h100000, 23'h402C09, 23'h002C89, 23'h440011,
		23'h440012, 23'h040011, 23'h4CC01F, 23'h4CE01F, 23'h0CC01F,
		23'h101F1F, 23'h50FFFF, 23'h101F1F, 23'h7CFFFF, 23'h3C0000};
	logic [5:0] mt [8] = '{6'h09, 6'h12, 6'h1B, 6'h2B, 6'h33, 6'h3F,
		6'h00, 6'h24};
	logic [6:0] code [6] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h06, 7'h0C};
	cmf_mode_fifo #(.BIT_CYCLES(BIT_CYCLES)) i_cmf_mode_fifo (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i({16'h0000, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack),
		.can_rx_i(rx), .device_idle_i(idle), .msg_rx_i(msg),
		.filter_hit_i(5'h0F), .rx_buf_i(4'hC), .rx_buf_irq_i(ev[5]),
		.tx_buf_i(4'h6), .tx_buf_irq_i(ev[4]), .wake_i(ev[1]),
		.rx_ovf_i(ev[2]), .fifo_almost_i(ev[3]),
		.err_state_i({5'h00, ev[0]}), .tx_pending_i(pend),
		.fifo_read_i(fread), .current_op_field_o(cur), .module_run_o(run),
		.abort_all_tx_o(abt), .module_clk_select_o(cks),
		.rx_capture_o(cap), .map_window_select_o(map_window_select),
		.data_match_bit_count_o(dnc), .dma_buffer_count_o(dma));
	cmf_bus_node #(.BIT_CYCLES(BIT_CYCLES)) i_cmf_bus_node (
		.clk_i(clk_i), .busy_i(busy), .can_rx_o(rx));
	initial forever #20 clk_i = ~clk_i;
	task complete_run;
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// Reads compare against d; the bench timeout ends a hung wait
	task bus(input w, input [5:0] a, input [15:0] d);
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		if (!w) chk(rdat, {16'h0000, d});
		cyc <= 0;
		@(posedge clk_i);
	endtask
	task mode(input [2:0] rq, input [2:0] ex);
		bus(1, 6'h00, {5'h05, rq, 8'h09});
		repeat (80) @(posedge clk_i);
		chk(cur, ex);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		for (i = 0; i < 18; i++)
			bus(rows[i][22], rows[i][21:16], rows[i][15:0]);
		chk({cks, map_window_select, dnc, dma}, {2'b11, 5'h11, 3'h6});
		busy <= 1;
		repeat (16) @(posedge clk_i);
		mode(3'h0, 3'h4);
		busy <= 0;
		for (i = 0; i < 8; i++)
			mode(mt[i][5:3], mt[i][2:0]);
		msg <= 1;
		@(posedge clk_i);
		msg <= 0;
		@(posedge clk_i);
		chk(cap, 1'b1);
		for (i = 0; i < 6; i++) begin
			ev <= 6'h01 << i;
			@(posedge clk_i);
			ev <= 0;
			@(posedge clk_i);
			bus(1, 6'h14, 16'h001F);
			bus(0, 6'h08, {8'h0F, 1'b0, code[i]});
			bus(1, 6'h14, 16'h0000);
			bus(0, 6'h08, 16'h0F40);
		end
		idle <= 1;
		repeat (3) @(posedge clk_i);
		chk(run, 1'b0);
		idle <= 0;
		pend <= 1;
		bus(1, 6'h00, {5'h07, 3'h4, 8'h09});
		repeat (3) @(posedge clk_i);
		chk({run, abt}, 2'b11);
		pend <= 0;
		repeat (4) @(posedge clk_i);
		chk(abt, 1'b0);
		bus(1, 6'h00, 16'h2401);
		bus(1, 6'h0C, 16'hC01E);
		msg <= 1;
		@(posedge clk_i);
		msg <= 0;
		@(posedge clk_i);
		chk(cap, 1'b0);
		bus(0, 6'h10, 16'h1F1E);
		msg <= 1;
		fread <= 1;
		@(posedge clk_i);
		msg <= 0;
		fread <= 0;
		@(posedge clk_i);
		bus(0, 6'h10, 16'h1E1F);
		complete_run;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		complete_run;
	end
endmodule
bind cmf_mode_fifo cmf_chk #(.BIT_CYCLES(BIT_CYCLES)) i_cmf_chk (.*);
